// File: logic/ftts_selector.sv
// How it works
// - Unsynchronized or grandmaster-less inputs are untrusted.
// - Dependent inputs share one dependent selector.
// - Dependent selector yields one input or not_qualified.
// - Multi-domain: independent selector sees dependent result.
// - Single-domain: all inputs feed independent selector.
// - Single-time: sole input passes unqualified.
// - Oscillator clock may serve as frequency reference.
// - Chosen time drives the module time output.
// - Not_qualified time clears both trust flags.
// - Not_qualified copies remaining fields from one input.
// - Both selectors use the same mid-value procedure.
// - Each pair within threshold trusts both members.
// - Pick median trusted time, lower on even.
// - Hysteresis widens threshold for already trusted pairs.
// - Thresholds unsigned 32-bit in 2^-16 ns.
// - Selected index is 1..255 or not_qualified.
// - Partner index names the next higher trusted.
// - Exclusion vector tracks placed indexes while sorting.
// - Output matches input type, carries phase discontinuity.
// - Skews computed and trust cleared each round.
// - Trust sets at threshold, holds at threshold+hysteresis.
// - Independent mode keeps prior choice while input valid.
// - At least one input, not_qualified not counted.
`timescale 1ns/10ps
`default_nettype none
`include "ftts_defines.svh"

module ftts_selector
(
	input  wire logic                    clock_i,
	input  wire logic                    rst_i,
	input  wire ftts_pkg::ftts_mode_e    mode_i,
	input  wire ftts_pkg::ftts_time_s    time_i [`FTTS_NUM_IN],
	input  wire logic [`FTTS_NUM_IN-1:0] time_valid_i,
	input  wire logic [`FTTS_SKEW_W-1:0] pair_skew_threshold_i [`FTTS_NUM_IN][`FTTS_NUM_IN],
	input  wire logic [`FTTS_SKEW_W-1:0] pair_hysteresis_i [`FTTS_NUM_IN][`FTTS_NUM_IN],
	output logic                         time_valid_o,
	output ftts_pkg::ftts_time_s         module_time_output_o,
	output ftts_pkg::ftts_sel_s          dependent_sel_o,
	output ftts_pkg::ftts_sel_s          independent_sel_o,
	output ftts_pkg::ftts_trust_e        frequency_holdover_state_o
);
	import ftts_pkg::*;

	localparam int N = `FTTS_NUM_IN;
	localparam int ND = `FTTS_NUM_DEP;
	// Independent selector sees the dependent result plus the remaining inputs.
	localparam int NI = N - ND + 1;

	typedef struct packed
	{
		ftts_sel_s   sel;
		logic [N*N-1:0] pair_trust;
		ftts_trust_e trust;
	} ftts_mv_s;

	function automatic logic [`FTTS_TOD_W-1:0] abs_diff(input logic [`FTTS_TOD_W-1:0] a,
		input logic [`FTTS_TOD_W-1:0] b);
		abs_diff = (a >= b) ? (a - b) : (b - a);
	endfunction

	// Widen a threshold to time units: low 16 bits are fractional ns, as is the time count.
	function automatic logic [`FTTS_TOD_W-1:0] widen(input logic [`FTTS_SKEW_W:0] v);
		widen = {{(`FTTS_TOD_W-`FTTS_SKEW_W-1){1'b0}}, v};
	endfunction

	function automatic ftts_time_s not_qualified(input ftts_time_s t);
		ftts_time_s r;
		r = t;
		r.synchronized_flag = 1'b0;
		r.grandmaster_present_flag = 1'b0;
		not_qualified = r;
	endfunction

	function automatic ftts_mv_s mid_value(
		input ftts_time_s t [N],
		input int unsigned cnt,
		input logic [`FTTS_SKEW_W-1:0] thr [N][N],
		input logic [`FTTS_SKEW_W-1:0] hys [N][N],
		input logic [N*N-1:0] prev_pair,
		input ftts_sel_s prev_sel,
		input ftts_trust_e prev_trust,
		input logic independent_mode);
		ftts_mv_s r;
		logic [N-1:0] trusted;
		logic [N-1:0] excl;
		logic [N-1:0] ok;
		logic [`FTTS_TOD_W-1:0] diff;
		logic [`FTTS_TOD_W-1:0] minv;
		int unsigned order [N+1];
		int unsigned nsort;
		int unsigned pick;
		int unsigned pidx;
		logic hit;
		r.sel = prev_sel;
		r.pair_trust = '0;
		r.trust = FTTS_NO_TRUST;
		trusted = '0;
		excl = '0;
		nsort = 0;
		pidx = 0;
		for (int k = 0; k <= N; k++)
			order[k] = 0;
		for (int k = 0; k < N; k++)
			ok[k] = t[k].synchronized_flag & t[k].grandmaster_present_flag;
		for (int x = 0; x < N - 1; x++)
			for (int y = x + 1; y < N; y++)
				if (x < cnt && y < cnt)
				begin
					diff = abs_diff(t[x].callback_time, t[y].callback_time);
					if (ok[x] && ok[y] &&
						((!prev_pair[x*N+y] && diff <= widen({1'b0, thr[x][y]})) ||
						(prev_pair[x*N+y] &&
						diff <= widen({1'b0, thr[x][y]} + {1'b0, hys[x][y]}))))
					begin
						r.pair_trust[x*N+y] = 1'b1;
						trusted[x] = 1'b1;
						trusted[y] = 1'b1;
						r.trust = FTTS_TIME_TRUST;
					end
				end
		if (r.trust == FTTS_TIME_TRUST)
		begin
			// Equal times keep the later index, as the search takes the last minimum.
			// ascending sort with exclusion
			for (int s = 0; s < N; s++)
			begin
				minv = `FTTS_TOD_MAX;
				hit = 1'b0;
				pick = 0;
				for (int y = 0; y < N; y++)
					if (trusted[y] && !excl[y] && t[y].callback_time <= minv)
					begin
						minv = t[y].callback_time;
						pick = y;
						hit = 1'b1;
					end
				if (hit)
				begin
					excl[pick] = 1'b1;
					nsort = nsort + 1;
					order[nsort] = pick + 1;
				end
			end
			r.sel.selected = ftts_idx_t'(order[(nsort + 1) / 2]);
			r.sel.partner = ftts_idx_t'(order[(nsort + 1) / 2 + 1]);
		end
		else
		begin
			// Index zero names no input, so there is nothing to hold.
			if (prev_sel.selected != `FTTS_NQ_IDX)
				pidx = int'(prev_sel.selected) - 1;
			if (independent_mode && prev_trust != FTTS_NO_TRUST &&
				prev_sel.selected != `FTTS_NQ_IDX && pidx < N && ok[pidx])
				r.trust = FTTS_FREQUENCY_HOLDOVER_STATE;
			else
			begin
				r.sel.selected = `FTTS_NQ_IDX;
				r.sel.partner = `FTTS_NQ_IDX;
			end
		end
		mid_value = r;
	endfunction

	function automatic ftts_time_s pick_time(input ftts_time_s t [N], input ftts_idx_t idx);
		pick_time = not_qualified(t[0]);
		for (int k = 0; k < N; k++)
			if (idx == ftts_idx_t'(k + 1))
				pick_time = t[k];
	endfunction

	ftts_sel_s           dep_sel;
	ftts_sel_s           ind_sel;
	ftts_trust_e         dep_trust;
	ftts_trust_e         ind_trust;
	logic [N*N-1:0]      dep_pair;
	logic [N*N-1:0]      ind_pair;
	ftts_time_s          snap [N];
	logic [N-1:0]        arrived;
	logic                round_go;
	logic                round_eval;

	// Strobes landing in the evaluation cycle count toward the next round.
	// wait for all samples
	wire logic all_arrived = &(arrived | time_valid_i);
	assign round_go = all_arrived && !round_eval;

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			arrived <= '0;
			round_eval <= 1'b0;
			snap <= '{default: '0};
		end
		else
		begin
			round_eval <= round_go;
			arrived <= round_go ? '0 : (arrived | time_valid_i);
			for (int k = 0; k < N; k++)
				if (time_valid_i[k])
					snap[k] <= time_i[k];
		end
	end

	// Slots past the dependent group hold a filler that the count leaves out.
	// one dependent group, inputs 0..ND-1
	ftts_time_s dep_in [N];
	always_comb
	begin
		for (int k = 0; k < N; k++)
			dep_in[k] = (k < ND) ? snap[k] : not_qualified(snap[0]);
	end

	wire ftts_mv_s dep_res = mid_value(dep_in, ND, pair_skew_threshold_i, pair_hysteresis_i,
		dep_pair, dep_sel, dep_trust, 1'b0);
	wire ftts_time_s dep_time = (dep_res.sel.selected == `FTTS_NQ_IDX) ?
		not_qualified(snap[0]) : pick_time(snap, dep_res.sel.selected);

	ftts_time_s ind_in [N];
	always_comb
	begin
		for (int k = 0; k < N; k++)
			if (mode_i == FTTS_MODE_MULTI_DOMAIN)
				ind_in[k] = (k == 0) ? dep_time :
					((k < NI) ? snap[k + ND - 1] : not_qualified(snap[0]));
			else
				ind_in[k] = snap[k];
	end

	wire logic [31:0] ind_cnt = (mode_i == FTTS_MODE_MULTI_DOMAIN) ? NI : N;
	wire ftts_mv_s ind_res = mid_value(ind_in, ind_cnt, pair_skew_threshold_i,
		pair_hysteresis_i, ind_pair, ind_sel, ind_trust, 1'b1);

	// A held selection reads its time from the current snapshot.
	// single-time pass-through
	wire ftts_sel_s next_ind_sel = (mode_i == FTTS_MODE_SINGLE_TIME) ?
		ftts_sel_s'{selected: 8'h01, partner: `FTTS_NQ_IDX} : ind_res.sel;
	wire ftts_time_s next_out = (mode_i == FTTS_MODE_SINGLE_TIME) ? snap[0] :
		((next_ind_sel.selected == `FTTS_NQ_IDX) ? not_qualified(ind_in[0]) :
		ind_in[int'(next_ind_sel.selected) - 1]);

	always_ff @(posedge clock_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			dep_sel <= '0;
			ind_sel <= '0;
			dep_trust <= FTTS_NO_TRUST;
			ind_trust <= FTTS_NO_TRUST;
			dep_pair <= '0;
			ind_pair <= '0;
			module_time_output_o <= '0;
			time_valid_o <= 1'b0;
		end
		else
		begin
			time_valid_o <= round_eval;
			if (round_eval)
			begin
				dep_sel <= dep_res.sel;
				dep_trust <= dep_res.trust;
				dep_pair <= dep_res.pair_trust;
				ind_sel <= next_ind_sel;
				ind_trust <= ind_res.trust;
				ind_pair <= ind_res.pair_trust;
				module_time_output_o <= next_out;
			end
		end
	end

	assign dependent_sel_o = dep_sel;
	assign independent_sel_o = ind_sel;
	assign frequency_holdover_state_o = ind_trust;

endmodule

`default_nettype wire

// File: logic/ftts_defines.svh
`ifndef FTTS_DEFINES_SVH
`define FTTS_DEFINES_SVH

// Number of time inputs and how many of them form the dependent group.
`define FTTS_NUM_IN       4
`define FTTS_NUM_DEP      2
`define FTTS_IDX_W        8
// Time of day: 48-bit seconds plus 32-bit nanoseconds times 2^16 as one 96-bit count.
`define FTTS_TOD_W        96
// Skew thresholds and hysteresis are unsigned, in units of 2^-16 ns.
`define FTTS_SKEW_W       32
`define FTTS_SKEW_FRAC    16
`define FTTS_NQ_IDX       8'h00
`define FTTS_TOD_MAX      96'hFFFF_FFFF_FFFF_FFFF_FFFF_FFFF

`endif

// File: logic/ftts_pkg.sv
`default_nettype none
`include "ftts_defines.svh"

package ftts_pkg;

	typedef enum logic [2:0]
	{
		FTTS_MODE_MULTI_DOMAIN = 3'b001,
		FTTS_MODE_SINGLE_DOMAIN = 3'b010,
		FTTS_MODE_SINGLE_TIME = 3'b100
	} ftts_mode_e;

	typedef enum logic [2:0]
	{
		FTTS_NO_TRUST = 3'b001,
		FTTS_TIME_TRUST = 3'b010,
		FTTS_FREQUENCY_HOLDOVER_STATE = 3'b100
	} ftts_trust_e;

	typedef logic [`FTTS_IDX_W-1:0] ftts_idx_t;

	// One time interface as carried between the endpoints, selectors and consumer.
	typedef struct packed
	{
		logic [7:0]              domain_number;
		logic [`FTTS_TOD_W-1:0]  callback_time;
		logic                    synchronized_flag;
		logic                    grandmaster_present_flag;
		logic [7:0]              error_condition;
		logic [31:0]             clock_period;
		logic [63:0]             grandmaster_identity;
		logic [15:0]             time_base_indicator;
		logic [`FTTS_TOD_W-1:0]  last_phase_change;
		logic [31:0]             last_freq_change;
		logic                    phase_discontinuity;
	} ftts_time_s;

	typedef struct packed
	{
		ftts_idx_t selected;
		ftts_idx_t partner;
	} ftts_sel_s;

endpackage

`default_nettype wire

// File: testbench/ftts_selector_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftts_defines.svh"

module ftts_selector_asserts
(
	input  wire logic                          clock_i,
	input  wire logic                          rst_i,
	input  wire ftts_pkg::ftts_mode_e          mode_i,
	input  wire logic [`FTTS_NUM_IN-1:0]       time_valid_i,
	input  wire logic                          time_valid_o,
	input  wire ftts_pkg::ftts_time_s          module_time_output_o,
	input  wire ftts_pkg::ftts_sel_s           dependent_sel_o,
	input  wire ftts_pkg::ftts_sel_s           independent_sel_o,
	input  wire ftts_pkg::ftts_trust_e         frequency_holdover_state_o
);
	import ftts_pkg::*;

	logic [`FTTS_NUM_IN-1:0] seen;
	logic                    busy;
	wire                     round_go = &(seen | time_valid_i) && !busy;
	wire                     out_nq = independent_sel_o.selected == `FTTS_NQ_IDX;
	wire                     out_ok = module_time_output_o.synchronized_flag
		&& module_time_output_o.grandmaster_present_flag;
	wire                     multi = mode_i != FTTS_MODE_SINGLE_TIME;

	// Tracks which inputs have delivered since the last round began; rounds are at least two cycles apart.
	always_ff @(posedge clock_i or posedge rst_i)
		if (rst_i)
		begin
			seen <= '0;
			busy <= 1'b0;
		end
		else
		begin
			seen <= round_go ? '0 : (seen | time_valid_i);
			busy <= round_go;
		end

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);

	sequence round_s;
		round_go;
	endsequence
	sequence answer_s;
		!time_valid_o ##1 time_valid_o;
	endsequence

	round_latency_a: assert property (round_s |=> answer_s)
		else $error("no answer two cycles after a full set of samples");
	no_spurious_a: assert property (time_valid_o |-> $past(round_go, 2))
		else $error("output without a full set of samples");
	pulse_once_a: assert property (time_valid_o |=> !time_valid_o)
		else $error("output strobe longer than one cycle");
	out_hold_a: assert property (!time_valid_o |-> $stable(module_time_output_o)
		&& $stable(independent_sel_o)) else $error("output changed between rounds");
	nq_flags_a: assert property (time_valid_o && out_nq
		|-> !module_time_output_o.synchronized_flag
		&& !module_time_output_o.grandmaster_present_flag)
		else $error("not qualified flags set");
	trusted_flags_a: assert property (time_valid_o && !out_nq && multi |-> out_ok)
		else $error("untrusted input chosen");
	sel_range_a: assert property (time_valid_o |-> independent_sel_o.selected <= 8'h04
		&& dependent_sel_o.selected <= 8'h02) else $error("index out of range");
	single_time_a: assert property (time_valid_o && !multi
		|-> independent_sel_o.selected == 8'h01 && independent_sel_o.partner == 8'h00)
		else $error("single time not passed through");
	partner_diff_a: assert property (time_valid_o && independent_sel_o.partner != 8'h00
		|-> !out_nq && independent_sel_o.partner != independent_sel_o.selected)
		else $error("partner equals selected");
	no_trust_nq_a: assert property (time_valid_o && multi
		&& frequency_holdover_state_o == FTTS_NO_TRUST |-> out_nq)
		else $error("selection kept without trust");
endmodule

bind ftts_selector ftts_selector_asserts u_chk
(
	.clock_i, .rst_i, .mode_i, .time_valid_i, .time_valid_o, .module_time_output_o,
	.dependent_sel_o, .independent_sel_o, .frequency_holdover_state_o
);

`default_nettype wire

// File: testbench/ftts_endpoint_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftts_defines.svh"

module ftts_endpoint_model
(
	input  wire logic                 clock_i,
	input  wire logic [3:0]           go_i,
	input  wire logic [3:0]           ok_i,
	input  wire logic [7:0]           tag_i,
	input  wire logic [95:0]          base_i,
	input  wire logic [31:0]          off_i [4],
	output ftts_pkg::ftts_time_s      time_o [4],
	output logic [3:0]                valid_o
);
	import ftts_pkg::*;

	ftts_time_s fresh;

	initial
	begin
		valid_o = 4'h0;
		foreach (time_o[k])
			time_o[k] = '0;
	end

	// A quiet endpoint flips its lines each cycle so stale data never looks current.
	always @(negedge clock_i)
		for (int k = 0; k < 4; k++)
		begin
			fresh = '0;
			fresh.domain_number = tag_i + 8'(k);
			fresh.callback_time = base_i + 96'(off_i[k]);
			fresh.synchronized_flag = ok_i[k];
			fresh.grandmaster_present_flag = ok_i[k];
			fresh.grandmaster_identity = {8{tag_i}};
			valid_o[k] <= go_i[k];
			time_o[k] <= go_i[k] ? fresh : ~time_o[k];
		end
endmodule

`default_nettype wire

// File: testbench/tb_fault_tolerant_time_selector.sv
`timescale 1ns/10ps
`default_nettype none
`include "ftts_defines.svh"

module tb_fault_tolerant_time_selector;
	import ftts_pkg::*;

	typedef struct packed
	{
		ftts_sel_s      ind;
		ftts_sel_s      dep;
		logic           chk_dep;
		logic           flag;
		logic [95:0]    cb;
		logic [7:0]     dom;
		ftts_trust_e    tr;
	} ftts_exp_s;

	localparam ftts_mode_e  sdom = FTTS_MODE_SINGLE_DOMAIN;
	localparam ftts_mode_e  mdom = FTTS_MODE_MULTI_DOMAIN;
	localparam ftts_mode_e  stime = FTTS_MODE_SINGLE_TIME;
	localparam ftts_trust_e no_tr = FTTS_NO_TRUST;
	localparam ftts_trust_e tm_tr = FTTS_TIME_TRUST;
	localparam ftts_trust_e fq_tr = FTTS_FREQUENCY_HOLDOVER_STATE;

	logic            clock_i = 1'b0;
	logic            rst_i = 1'b1;
	ftts_mode_e      mode = FTTS_MODE_SINGLE_DOMAIN;
	logic [3:0]      go = 4'h0;
	logic [3:0]      ok = 4'hf;
	logic [7:0]      tag = 8'h00;
	logic [95:0]     base = '0;
	logic [31:0]     off [4] = '{default: '0};
	logic [31:0]     thr [4][4] = '{default: 32'h0000_0064};
	logic [31:0]     hys [4][4] = '{default: 32'h0000_0032};
	ftts_time_s      tin [4];
	logic [3:0]      vin;
	logic            vout;
	ftts_time_s      tout;
	ftts_sel_s       dsel;
	ftts_sel_s       isel;
	ftts_trust_e     fhs;
	ftts_exp_s       q [$];
	int              num_errors = 0;
	int              compares = 0;

	always #4 clock_i = ~clock_i;

	ftts_endpoint_model ep (.clock_i(clock_i), .go_i(go), .ok_i(ok), .tag_i(tag),
		.base_i(base), .off_i(off), .time_o(tin), .valid_o(vin));
	ftts_selector dut (.clock_i(clock_i), .rst_i(rst_i), .mode_i(mode), .time_i(tin),
		.time_valid_i(vin), .pair_skew_threshold_i(thr), .pair_hysteresis_i(hys),
		.time_valid_o(vout), .module_time_output_o(tout), .dependent_sel_o(dsel),
		.independent_sel_o(isel), .frequency_holdover_state_o(fhs));

	task bad(input string s);
		$display("BAD %0t %s", $time, s);
		num_errors++;
	endtask

	task cmp_out(input ftts_exp_s e);
		compares++;
		if (isel !== e.ind || tout.synchronized_flag !== e.flag || tout.callback_time !== e.cb
			|| tout.grandmaster_present_flag !== e.flag || tout.domain_number !== e.dom
			|| (e.chk_dep && dsel !== e.dep) || fhs !== e.tr)
			bad("selected time differs");
	endtask

	task complete_run;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One evaluation round: fresh random time base, strobes together or one per cycle.
	task run(input ftts_mode_e m, input logic [3:0] k, input int o [4], input logic stag,
		input ftts_sel_s ei, input int src, input logic f, input ftts_trust_e tr);
		int i;
		@(negedge clock_i);
		mode <= m;
		ok <= k;
		tag <= 8'($urandom);
		base <= {16'h0000, $urandom, $urandom, 16'h0000};
		foreach (off[j])
			off[j] <= o[j];
		@(negedge clock_i);
		q.push_back('{ei, '{8'h01, 8'h02}, m == FTTS_MODE_MULTI_DOMAIN, f,
			base + 96'(o[src]), tag + 8'(src), tr});
		for (i = 0; i < (stag ? 4 : 1); i++)
		begin
			go <= stag ? 4'(1 << i) : 4'hf;
			@(negedge clock_i);
		end
		go <= 4'h0;
		for (i = 0; i < 20 && q.size() > 0; i++)
			@(negedge clock_i);
	endtask

	always @(negedge clock_i)
		if (vout === 1'b1)
		begin
			if (q.size() == 0)
				bad("unexpected output");
			else
				cmp_out(q.pop_front());
		end

	initial
	begin
		void'($urandom(57551));
		repeat (3) @(posedge clock_i);
		@(negedge clock_i);
		rst_i <= 1'b0;
		run(sdom, 4'hf, '{0, 10, 20, 1000}, 1'b0, '{8'h02, 8'h03}, 1, 1'b1, tm_tr);
		run(sdom, 4'hf, '{0, 10, 1000, 2000}, 1'b1, '{8'h01, 8'h02}, 0, 1'b1, tm_tr);
		run(sdom, 4'he, '{0, 10, 20, 30}, 1'b0, '{8'h03, 8'h04}, 2, 1'b1, tm_tr);
		run(sdom, 4'hf, '{0, 90, 5000, 10000}, 1'b0, '{8'h01, 8'h02}, 0, 1'b1, tm_tr);
		run(sdom, 4'hf, '{0, 130, 5000, 10000}, 1'b0, '{8'h01, 8'h02}, 0, 1'b1, tm_tr);
		run(sdom, 4'he, '{0, 1000, 5000, 10000}, 1'b0, '{8'h00, 8'h00}, 0, 1'b0, no_tr);
		run(sdom, 4'hf, '{0, 130, 5000, 10000}, 1'b0, '{8'h00, 8'h00}, 0, 1'b0, no_tr);
		run(sdom, 4'hf, '{0, 10, 5000, 10000}, 1'b1, '{8'h01, 8'h02}, 0, 1'b1, tm_tr);
		run(sdom, 4'hf, '{0, 1000, 5000, 10000}, 1'b0, '{8'h01, 8'h02}, 0, 1'b1, fq_tr);
		run(mdom, 4'hf, '{0, 10, 20, 30}, 1'b0, '{8'h02, 8'h03}, 2, 1'b1, tm_tr);
		run(stime, 4'h0, '{7, 900, 5000, 10000}, 1'b1, '{8'h01, 8'h00}, 0, 1'b0, no_tr);
		if (q.size() != 0)
			bad("missing output");
		complete_run();
	end

	initial
	begin
		#20000;
		bad("timeout");
		complete_run();
	end
endmodule

`default_nettype wire
